//--- rtl/cst_safety_timer.sv
// The register offsets and register access over Avalon-MM were chosen for this implementation.
module cst_safety_timer #(
    parameter int TICK_CYCLES = cst_pkg::CST_TICK_CYCLES, // cycles per timer tick
    parameter int IRQ_CYCLES = cst_pkg::CST_IRQ_CYCLES // interrupt pulse length
) (
    input wire logic ref_clk, // 40 MHz clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [3:0] avs_address, // byte address
    input wire logic avs_read, // read strobe
    input wire logic avs_write, // write strobe
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire cst_pkg::cst_sense_t sense_in, // charger core and pin levels
    output logic int_n, // interrupt pulse, active low
    output logic charge_allow, // temperature permits charging
    output logic [1:0] current_scale_code, // applied cool zone scale
    output logic [2:0] voltage_select_code, // applied warm voltage target
    output logic terminate_ok, // termination criteria met
    output logic reverse_switch_allow, // reverse output may switch
    output logic input_source_force_zero, // input source status forced 000
    output logic [1:0] cool_threshold_select, // to programmable comparator
    output logic [1:0] warm_threshold_select, // to programmable comparator
    output logic [2:0] timer_fault // trickle, pre, fast expired
);
    import cst_pkg::*;

    // ----------------------------------------
    // input synchroniser
    // ----------------------------------------
    cst_sense_t sync1_reg; // first stage, read only by second
    cst_sense_t sns_reg; // safe copy for logic

    // every sense bit is asynchronous to ref_clk
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_reg <= '0;
            sns_reg <= '0;
        end else begin
            sync1_reg <= sense_in;
            sns_reg <= sync1_reg;
        end
    end

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    cst_ctrl_t ctrl_reg; // control register
    cst_temp_t temp_reg; // zone settings
    logic ack_reg; // answer phase of an access
    logic [31:0] stat_word; // live status word
    logic [7:0] flag_reg; // sticky flags
    logic [7:0] flag_set; // flag set events this cycle
    logic wr_take; // write takes effect
    logic rd_take; // read completes

    // one wait cycle, then the access completes
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_take = avs_write & ack_reg;
    assign rd_take = avs_read & ack_reg;

    // merge write data under byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        be_merge = (old & ~m) | (wd & m);
    endfunction

    // handshake and read data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            avs_readdata <= '0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
            case (avs_address) // unmapped reads return zero
                CST_ADDR_CTRL: avs_readdata <= {20'h0_0000, ctrl_reg};
                CST_ADDR_TEMP: avs_readdata <= {23'h00_0000, temp_reg};
                CST_ADDR_STAT: avs_readdata <= stat_word;
                CST_ADDR_FLAG: avs_readdata <= {24'h00_0000, flag_reg};
                default: avs_readdata <= '0;
            endcase
        end
    end

    // writable registers, unmapped writes ignored
    always_ff @(posedge ref_clk) begin
        logic [31:0] nw;
        nw = '0;
        if (rst) begin
            ctrl_reg <= CST_CTRL_RST;
            temp_reg <= CST_TEMP_RST;
        end else if (wr_take && avs_address == CST_ADDR_CTRL) begin
            nw = be_merge({20'h0_0000, ctrl_reg}, avs_writedata, avs_byteenable);
            ctrl_reg <= nw[11:0];
        end else if (wr_take && avs_address == CST_ADDR_TEMP) begin
            nw = be_merge({23'h00_0000, temp_reg}, avs_writedata, avs_byteenable);
            temp_reg <= nw[8:0];
        end
    end

    // flags clear on read, a same-cycle event survives
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flag_reg <= '0;
        end else if (rd_take && avs_address == CST_ADDR_FLAG) begin
            flag_reg <= flag_set;
        end else begin
            flag_reg <= flag_reg | flag_set;
        end
    end

    // ----------------------------------------
    // temperature zones
    // ----------------------------------------
    cst_zone_t zone_raw; // zone from comparators
    cst_zone_t zone_reg; // reported zone
    logic in_window; // inside cold-hot window
    logic zone_susp; // zone suspends charging
    logic zone_reduce; // zone reduces current

    // fixed cold/hot comparators outrank the programmable pair
    assign cool_threshold_select = temp_reg.cool_threshold_select;
    assign warm_threshold_select = temp_reg.warm_threshold_select;
    always_comb begin
        if (ctrl_reg.thermistor_ignore) begin
            zone_raw = CST_Z_NORMAL;
        end else if (sns_reg.above_hot) begin
            zone_raw = CST_Z_HOT;
        end else if (sns_reg.below_cold) begin
            zone_raw = CST_Z_COLD;
        end else if (sns_reg.below_cool) begin
            zone_raw = CST_Z_COOL;
        end else if (sns_reg.above_warm) begin
            zone_raw = CST_Z_WARM;
        end else begin
            zone_raw = CST_Z_NORMAL;
        end
    end

    // zone register tracks comparators
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            zone_reg <= CST_Z_NORMAL;
        end else begin
            zone_reg <= zone_raw;
        end
    end

    // zone effects on charge current, voltage and reverse output
    assign in_window = (zone_reg != CST_Z_COLD) && (zone_reg != CST_Z_HOT);
    assign zone_susp = !in_window
        || (zone_reg == CST_Z_COOL && temp_reg.cool_zone_current_scale == CST_SCALE_SUSP)
        || (zone_reg == CST_Z_WARM && temp_reg.warm_zone_voltage_select == CST_VSEL_SUSP);
    // codes 01 and 10 are the 20 % and 40 % settings
    assign zone_reduce = zone_reg == CST_Z_COOL && !temp_reg.cool_zone_current_scale[1] !=
        !temp_reg.cool_zone_current_scale[0];

    // registered zone outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            charge_allow <= 1'b0;
            current_scale_code <= '0;
            voltage_select_code <= '0;
            terminate_ok <= 1'b0;
            reverse_switch_allow <= 1'b0;
            input_source_force_zero <= 1'b0;
        end else begin
            charge_allow <= in_window && !zone_susp;
            // full scale outside the cool zone
            current_scale_code <= (zone_reg == CST_Z_COOL) ? temp_reg.cool_zone_current_scale : 2'h3;
            // zero means normal target outside the warm zone
            voltage_select_code <= (zone_reg == CST_Z_WARM) ? temp_reg.warm_zone_voltage_select : 3'h0;
            // same threshold in every zone, held off during regulation
            terminate_ok <= ctrl_reg.term_enable && sns_reg.term_low && sns_reg.above_rechg
                && sns_reg.cv_loop && !(sns_reg.vin_reg || sns_reg.iin_reg || sns_reg.die_reg);
            reverse_switch_allow <= ctrl_reg.reverse_output_enable && in_window;
            input_source_force_zero <= ctrl_reg.reverse_output_enable && !in_window;
        end
    end

    // ----------------------------------------
    // time base and rate control
    // ----------------------------------------
    logic [25:0] pre_cnt_reg; // prescaler
    logic tick; // one-cycle timer tick
    logic half_phase_reg; // alternates on each tick that is not frozen
    logic half_hold_reg; // regulation half rate latched
    logic reg_any; // any regulation loop active
    logic half_rate; // timers at half rate
    logic freeze; // timers suspended
    logic step; // accepted tick

    assign tick = pre_cnt_reg == 26'(TICK_CYCLES - 1);
    assign reg_any = sns_reg.vin_reg | sns_reg.iin_reg | sns_reg.die_reg;
    assign half_rate = half_hold_reg | zone_reduce;
    assign freeze = sns_reg.charge_fault | sns_reg.supplement | zone_susp;
    assign step = tick && !freeze && (!half_rate || half_phase_reg);

    // prescaler from the oscillator
    always_ff @(posedge ref_clk) begin
        if (rst || tick) begin
            pre_cnt_reg <= '0;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 26'h000_0001;
        end
    end

    // clearing the enable bit only drops half rate when regulation ends
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            half_hold_reg <= 1'b0;
            half_phase_reg <= 1'b0;
        end else begin
            half_hold_reg <= reg_any && (ctrl_reg.double_time_enable || half_hold_reg);
            if (tick && !freeze) begin
                half_phase_reg <= !half_phase_reg;
            end
        end
    end

    // ----------------------------------------
    // stage timers
    // ----------------------------------------
    logic [1:0] stage_prev_reg; // stage one cycle ago
    cst_ctrl_t ctrl_prev_reg; // control one cycle ago
    logic ce_prev_reg; // pin one cycle ago
    logic rchg_prev_reg; // recharge one cycle ago
    logic restart; // charge stop and restart
    logic [2:0] tmr_en; // per-timer enables
    logic [2:0] tmr_clr; // per-timer clears
    logic [16:0] tmr_lim [3]; // per-timer limits
    logic [16:0] tmr_cnt_reg [3]; // per-timer counts
    logic [2:0] tmr_exp_reg; // expired status
    logic [2:0] tmr_hit; // expiry events
    logic [16:0] fast_lim; // decoded fast limit

    // true when the stage moves between lo and lo+1 either way
    function automatic logic stage_edge(input logic [1:0] p, input logic [1:0] c, input logic [1:0] lo);
        stage_edge = (p == lo && c == lo + 2'h1) || (p == lo + 2'h1 && c == lo);
    endfunction

    // history for edge detection
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage_prev_reg <= '0;
            ctrl_prev_reg <= CST_CTRL_RST;
            ce_prev_reg <= 1'b1;
            rchg_prev_reg <= 1'b0;
        end else begin
            stage_prev_reg <= sns_reg.stage;
            ctrl_prev_reg <= ctrl_reg;
            ce_prev_reg <= sns_reg.ce_n;
            rchg_prev_reg <= sns_reg.recharge;
        end
    end

    // pin or bit toggle back on, or recharge after termination
    assign restart = (ce_prev_reg && !sns_reg.ce_n)
        || (ctrl_reg.charge_enable_bit && !ctrl_prev_reg.charge_enable_bit)
        || (sns_reg.recharge && !rchg_prev_reg);
    assign tmr_en = {ctrl_reg.fast_timer_enable, ctrl_reg.precharge_timer_enable,
                     ctrl_reg.trickle_timer_enable};
    always_comb begin
        case (ctrl_reg.fast_timer_duration)
            2'h0: fast_lim = CST_FAST_S0;
            2'h1: fast_lim = CST_FAST_S1;
            2'h2: fast_lim = CST_FAST_S2;
            default: fast_lim = CST_FAST_S3;
        endcase
    end
    assign tmr_lim[0] = CST_TRICKLE_S;
    assign tmr_lim[1] = ctrl_reg.precharge_duration_select ? CST_PRE_SHORT_S : CST_PRE_LONG_S;
    assign tmr_lim[2] = fast_lim;
    assign tmr_clr[0] = restart || stage_edge(stage_prev_reg, sns_reg.stage, 2'h1);
    assign tmr_clr[1] = restart || stage_edge(stage_prev_reg, sns_reg.stage, 2'h1)
        || stage_edge(stage_prev_reg, sns_reg.stage, 2'h2)
        || (ctrl_reg.precharge_duration_select != ctrl_prev_reg.precharge_duration_select);
    assign tmr_clr[2] = restart || stage_edge(stage_prev_reg, sns_reg.stage, 2'h2)
        || (ctrl_reg.fast_timer_duration != ctrl_prev_reg.fast_timer_duration);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_tmr
            logic en_rise; // enable bit just set
            logic active; // this timer's stage is running
            assign en_rise = tmr_en[gi] && !(gi == 0 ? ctrl_prev_reg.trickle_timer_enable :
                gi == 1 ? ctrl_prev_reg.precharge_timer_enable : ctrl_prev_reg.fast_timer_enable);
            // stage code is timer index plus one
            assign active = tmr_en[gi] && sns_reg.stage == 2'(gi + 1);
            assign tmr_hit[gi] = active && step && tmr_cnt_reg[gi] + 17'h0_0001 >= tmr_lim[gi];

            // count runs only in its own stage; a disabled timer holds still
            always_ff @(posedge ref_clk) begin
                if (rst || tmr_clr[gi] || en_rise || (sns_reg.stage != stage_prev_reg
                        && sns_reg.stage == 2'(gi + 1))) begin
                    tmr_cnt_reg[gi] <= '0;
                end else if (active && step && tmr_cnt_reg[gi] < tmr_lim[gi]) begin
                    tmr_cnt_reg[gi] <= tmr_cnt_reg[gi] + 17'h0_0001;
                end
            end

            // expired status holds until the timer is cleared
            always_ff @(posedge ref_clk) begin
                if (rst || tmr_clr[gi] || en_rise) begin
                    tmr_exp_reg[gi] <= 1'b0;
                end else if (tmr_hit[gi]) begin
                    tmr_exp_reg[gi] <= 1'b1;
                end
            end
        end
    endgenerate
    assign timer_fault = tmr_exp_reg;

    // ----------------------------------------
    // status, flags and interrupt
    // ----------------------------------------
    logic zone_chg; // reported zone moved
    logic [3:0] zone_bits; // cold, cool, warm, hot
    logic irq_req; // pulse request
    cst_irq_t irq_state_reg; // pulse state
    logic [13:0] irq_cnt_reg; // pulse length counter

    assign zone_bits = {zone_reg == CST_Z_HOT, zone_reg == CST_Z_WARM,
                        zone_reg == CST_Z_COOL, zone_reg == CST_Z_COLD};
    assign zone_chg = zone_raw != zone_reg && !ctrl_reg.thermistor_ignore;
    // flag the zone being entered; the mask gates flag and pulse alike
    assign flag_set = {{4{zone_chg && !ctrl_reg.temp_zone_irq_mask}} & {zone_raw == CST_Z_HOT,
        zone_raw == CST_Z_WARM, zone_raw == CST_Z_COOL, zone_raw == CST_Z_COLD},
        1'b0, tmr_hit};
    assign irq_req = (zone_chg && !ctrl_reg.temp_zone_irq_mask) || (|tmr_hit);
    assign stat_word = {18'h0_0000, freeze, half_rate, zone_bits, 1'b0, zone_reg, 1'b0, tmr_exp_reg};

    // a request during a pulse is merged into that pulse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_state_reg <= CST_IRQ_IDLE;
            irq_cnt_reg <= '0;
        end else begin
            case (irq_state_reg)
                CST_IRQ_IDLE: begin
                    if (irq_req) begin
                        irq_state_reg <= CST_IRQ_PULSE;
                        irq_cnt_reg <= '0;
                    end
                end
                CST_IRQ_PULSE: begin
                    if (irq_cnt_reg == 14'(IRQ_CYCLES - 1)) begin
                        irq_state_reg <= CST_IRQ_IDLE;
                    end else begin
                        irq_cnt_reg <= irq_cnt_reg + 14'h0001;
                    end
                end
                default: irq_state_reg <= CST_IRQ_IDLE;
            endcase
        end
    end
    assign int_n = irq_state_reg != CST_IRQ_PULSE;
endmodule

//--- rtl/cst_pkg.sv
package cst_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] CST_ADDR_CTRL = 4'h0; // control and timer enables
    localparam logic [3:0] CST_ADDR_TEMP = 4'h4; // temperature zone settings
    localparam logic [3:0] CST_ADDR_STAT = 4'h8; // live status, read only
    localparam logic [3:0] CST_ADDR_FLAG = 4'hc; // sticky flags, cleared by read
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CST_STAT_TMR_LSB = 0; // trickle, pre, fast expired [2:0]
    localparam int CST_STAT_ZONE_LSB = 4; // zone code [6:4]
    localparam int CST_STAT_ZBIT_LSB = 8; // cold, cool, warm, hot [11:8]
    localparam int CST_STAT_HALF_BIT = 12; // timers at half rate
    localparam int CST_STAT_FRZ_BIT = 13; // timers frozen
    localparam int CST_FLAG_ZONE_LSB = 4; // zone flags [7:4]
    // ----------------------------------------
    // packed carriers
    // ----------------------------------------
    typedef struct packed {
        logic term_enable; // [11]
        logic temp_zone_irq_mask; // [10]
        logic reverse_output_enable; // [9]
        logic thermistor_ignore; // [8]
        logic double_time_enable; // [7]
        logic fast_timer_enable; // [6]
        logic precharge_timer_enable; // [5]
        logic trickle_timer_enable; // [4]
        logic precharge_duration_select; // [3] 0: long, 1: short
        logic [1:0] fast_timer_duration; // [2:1]
        logic charge_enable_bit; // [0]
    } cst_ctrl_t;
    typedef struct packed {
        logic [1:0] warm_threshold_select; // [8:7]
        logic [1:0] cool_threshold_select; // [6:5]
        logic [2:0] warm_zone_voltage_select; // [4:2]
        logic [1:0] cool_zone_current_scale; // [1:0]
    } cst_temp_t;
    typedef struct packed {
        logic ce_n; // charge enable pin, active low
        logic [1:0] stage; // 0 none, 1 trickle, 2 pre, 3 fast
        logic vin_reg; // input voltage regulation
        logic iin_reg; // input current regulation
        logic die_reg; // die temperature regulation
        logic charge_fault; // fault that disables charging
        logic supplement; // battery supplement mode
        logic recharge; // level, high after recharge restart
        logic below_cold; // thermistor below cold threshold
        logic below_cool; // thermistor below cool threshold
        logic above_warm; // thermistor above warm threshold
        logic above_hot; // thermistor above hot threshold
        logic term_low; // current below termination level
        logic above_rechg; // voltage above recharge level
        logic cv_loop; // battery voltage loop active
    } cst_sense_t;
    typedef enum logic [2:0] {
        CST_Z_NORMAL = 3'h0,
        CST_Z_COOL = 3'h1,
        CST_Z_WARM = 3'h2,
        CST_Z_COLD = 3'h3,
        CST_Z_HOT = 3'h4
    } cst_zone_t;
    typedef enum logic {CST_IRQ_IDLE = 1'b0, CST_IRQ_PULSE = 1'b1} cst_irq_t;
    // ----------------------------------------
    // reset values and encodings
    // ----------------------------------------
    localparam logic [11:0] CST_CTRL_RST = 12'h0f5; // timers on, fast 12 h, charge on
    localparam logic [8:0] CST_TEMP_RST = 9'h0ff; // mid thresholds, full scale
    localparam logic [1:0] CST_SCALE_SUSP = 2'h0; // cool zone suspend code
    localparam logic [2:0] CST_VSEL_SUSP = 3'h0; // warm zone suspend code
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CST_CLK_PERIOD_NS = 25; // 40 MHz
    localparam int CST_TICK_PERIOD_MS = 1000; // timer base, one second
    localparam int CST_TICK_CYCLES = CST_TICK_PERIOD_MS * 1_000_000 / CST_CLK_PERIOD_NS;
    localparam int CST_IRQ_PULSE_NS = 256_000; // 256 us
    localparam int CST_IRQ_CYCLES = CST_IRQ_PULSE_NS / CST_CLK_PERIOD_NS;
    localparam logic [16:0] CST_TRICKLE_S = 17'h0_0e10; // 1 h
    localparam logic [16:0] CST_PRE_LONG_S = 17'h0_1c20; // 2 h
    localparam logic [16:0] CST_PRE_SHORT_S = 17'h0_0708; // 0.5 h
    localparam logic [16:0] CST_FAST_S0 = 17'h0_4650; // 5 h
    localparam logic [16:0] CST_FAST_S1 = 17'h0_7080; // 8 h
    localparam logic [16:0] CST_FAST_S2 = 17'h0_a8c0; // 12 h
    localparam logic [16:0] CST_FAST_S3 = 17'h1_5180; // 24 h
endpackage

//--- verif/cst_safety_timer_props.sv
module cst_safety_timer_props import cst_pkg::*; #(parameter int IRQ_CYCLES = 8) (
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic [3:0] avs_address, // address
    input wire logic avs_write, // write
    input wire logic [31:0] avs_writedata, // data
    input wire logic avs_waitrequest, // stall
    input wire cst_pkg::cst_sense_t sense_in, // levels
    input wire logic int_n, // irq
    input wire logic charge_allow, // gate
    input wire logic terminate_ok, // term
    input wire logic [2:0] timer_fault // expiry
);
    timeunit 1ns / 1ps;
    wire wc = avs_write && !avs_waitrequest && avs_address == CST_ADDR_CTRL; // ctrl write lands
    logic [1:0] ctl; // mask, ignore shadow; full-word writes only
    int lc; // int_n low cycles
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge ref_clk) ctl <= rst ? 2'h0 : (wc ? {avs_writedata[10], avs_writedata[8]} : ctl);
    always_ff @(posedge ref_clk) lc <= (rst || int_n) ? 0 : lc + 1;
    property p_exp; (timer_fault & ~$past(timer_fault)) != 3'h0 |-> ##[0:2] !int_n; endproperty
    a_exp: assert property (p_exp) else $error("expiry without pulse");
    property p_len; $rose(int_n) |-> lc == IRQ_CYCLES; endproperty
    a_len: assert property (p_len) else $error("pulse length");
    property p_max; !int_n |-> lc < IRQ_CYCLES; endproperty
    a_max: assert property (p_max) else $error("pulse too long");
    property p_frz; sense_in.charge_fault [*5] |=> (timer_fault & ~$past(timer_fault)) == 3'h0; endproperty
    a_frz: assert property (p_frz) else $error("expiry while frozen");
    property p_hot; (sense_in.above_hot && !ctl[0]) [*5] |=> !charge_allow; endproperty
    a_hot: assert property (p_hot) else $error("charge while hot");
    property p_ign; ctl[0] [*5] |=> charge_allow; endproperty
    a_ign: assert property (p_ign) else $error("ignore not honoured");
    property p_trm; (!sense_in.term_low) [*5] |=> !terminate_ok; endproperty
    a_trm: assert property (p_trm) else $error("early termination");
    property p_zin; $rose(sense_in.above_hot) && ctl == 2'h0 |-> ##[1:6] !int_n; endproperty
    a_zin: assert property (p_zin) else $error("zone change without pulse");
endmodule
bind cst_safety_timer cst_safety_timer_props #(.IRQ_CYCLES(IRQ_CYCLES)) props_u (.*);

//--- verif/cst_host.sv
module cst_host (
    input wire logic ref_clk, // clock
    output logic [3:0] avs_address = 4'h0, // address
    output logic avs_read = 1'b0, // read
    output logic avs_write = 1'b0, // write
    output logic [31:0] avs_writedata = 32'h0000_0000, // data
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest // stall
);
    timeunit 1ns / 1ps;
    // hold the request until the edge that sees waitrequest low
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        {avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, d};
        // waitrequest and read data are both taken at the rising edge
        do @(posedge ref_clk); while (avs_waitrequest);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'h0;
    endtask
endmodule

//--- verif/cst_safety_timer_tb.sv
module cst_safety_timer_tb;
    timeunit 1ns / 1ps;
    import cst_pkg::*;
    localparam int LIM = 1800 * 4; // short pre-charge limit at a 4-cycle tick
    logic ref_clk = 1'b0, rst = 1'b1, avs_read, avs_write, avs_waitrequest, int_n, charge_allow, terminate_ok;
    logic reverse_switch_allow, input_source_force_zero;
    logic [1:0] current_scale_code, cool_threshold_select, warm_threshold_select;
    logic [2:0] voltage_select_code, timer_fault;
    logic [3:0] avs_address, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata, avs_readdata, q, rv;
    cst_sense_t sense_in = '0;
    int seed = 26, checked = 0, n_mismatch = 0;
    cst_safety_timer #(.TICK_CYCLES(4), .IRQ_CYCLES(8)) dut_u (.*);
    cst_host host_u (.*);
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic w6; repeat (6) @(posedge ref_clk); endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) n_mismatch++;
        if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic finish_test;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        host_u.xfer(1'b0, CST_ADDR_CTRL, 32'h0, q);
        check(q[3:1], 3'h2);
        host_u.xfer(1'b0, 4'h2, 32'h0, q);
        check(q, 32'h0000_0000);
        host_u.xfer(1'b1, CST_ADDR_CTRL, 32'h0000_007d, q);
        sense_in.stage <= 2'h2;
        repeat (2000) @(posedge ref_clk);
        sense_in.charge_fault <= 1'b1;
        repeat (1000) @(posedge ref_clk);
        sense_in.charge_fault <= 1'b0;
        repeat (LIM - 2050) @(posedge ref_clk);
        check(timer_fault, 3'h0);
        repeat (100) @(posedge ref_clk);
        check(timer_fault, 3'h2);
        for (int i = 0; i < 3; i++) begin
            rv = $random(seed);
            host_u.xfer(1'b1, CST_ADDR_TEMP, rv & 32'h0000_01ff, q);
            sense_in.below_cool <= 1'b1;
            w6;
            check({warm_threshold_select, cool_threshold_select}, rv[8:5]);
            check({current_scale_code, charge_allow}, {rv[1:0], rv[1:0] != 2'h0});
            {sense_in.below_cool, sense_in.above_warm} <= 2'h1;
            w6;
            check({voltage_select_code, charge_allow}, {rv[4:2], rv[4:2] != 3'h0});
            sense_in.above_warm <= 1'b0;
        end
        host_u.xfer(1'b1, CST_ADDR_CTRL, 32'h0000_02f5, q);
        sense_in.above_hot <= 1'b1;
        w6;
        check({charge_allow, reverse_switch_allow, input_source_force_zero}, 3'h1);
        host_u.xfer(1'b0, CST_ADDR_STAT, 32'h0, q);
        check(q[11:4], 8'h84);
        host_u.xfer(1'b0, CST_ADDR_FLAG, 32'h0, q);
        check(q[7:4], 4'he);
        host_u.xfer(1'b1, CST_ADDR_CTRL, 32'h0000_03f5, q);
        w6;
        host_u.xfer(1'b0, CST_ADDR_STAT, 32'h0, q);
        check({q[11:4], charge_allow, reverse_switch_allow, input_source_force_zero}, 11'h006);
        host_u.xfer(1'b1, CST_ADDR_CTRL, 32'h0000_02f5, q);
        sense_in.above_hot <= 1'b0;
        w6;
        check({reverse_switch_allow, input_source_force_zero}, 2'h2);
        finish_test;
    end
endmodule
